// >>> src/bhp_power_handshake.sv
`timescale 1ns/10ps
`include "bhp_params.svh"
module bhp_power_handshake #(
  parameter logic [15:0] SETTLE_CYC = 16'(`BHP_SETTLE_CYC),
  parameter logic [15:0] INIT_CYC = 16'(`BHP_INIT_CYC)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic core_power_enable,
  input wire logic device_wake_in,
  input wire logic wake_in_active_high,
  input wire logic host_wake_active_high,
  input wire logic sleep_criteria_met,
  input wire logic host_attention_req,
  input wire logic bt_clk_need,
  input wire logic wlan_clk_need,
  input wire logic lp_mode_req,
  input wire logic [15:0] lp_wake_interval,
  input wire bhp_pkg::bhp_rf_s sw_rf_pd,
  input wire bhp_pkg::bhp_rf_s pkt_rf_pd,
  input wire logic pkt_rf_active,
  output logic host_wake_out,
  output logic host_wake_oe,
  output logic ref_clock_request,
  output logic ref_clock_request_oe,
  output logic uart_flow_ready_n,
  output logic uart_flow_ready_oe,
  output logic ref_clock_ok,
  output logic core_awake,
  output logic low_power_osc_sel,
  output bhp_pkg::bhp_rf_s rf_power_down
);
  import bhp_pkg::*;

  // Registered state and its next value
  bhp_state_s s_q, s_d;
  // Synchronised wake request, already polarity corrected
  logic wake_req;
  // Synchronised core power enable
  logic pwr_on;

  // ****************************************
  // Decode helpers
  // ****************************************
  // True in the one state where host traffic is accepted
  function automatic logic st_is_awake(input bhp_state_e st);
    st_is_awake = (st == BHP_AWAKE);
  endfunction

  // True in the timed low-power state on the slow oscillator
  function automatic logic st_is_lowpwr(input bhp_state_e st);
    st_is_lowpwr = (st == BHP_LOWPWR);
  endfunction

  // Pin level to logical assertion under the selected polarity
  function automatic logic level_asserted(input logic lvl, input logic hi);
    level_asserted = lvl ~^ hi;
  endfunction

  // Logical assertion to pin level under the selected polarity
  function automatic logic level_drive(input logic act, input logic hi);
    level_drive = act ~^ hi;
  endfunction

  // All four RF sections powered down, the safe idle setting
  function automatic bhp_rf_s rf_all_off();
    rf_all_off = `BHP_RF_OFF;
  endfunction

  // ****************************************
  // Next-state logic
  // ****************************************
  // One pass computes every field; shutdown overrides at the end
  always_comb begin
    s_d = s_q;
    // Two-stage synchronisers for the asynchronous pins
    s_d.wake_sync = {s_q.wake_sync[0], device_wake_in};
    s_d.pwr_sync = {s_q.pwr_sync[0], core_power_enable};
    // Only the second stage is read by the logic below
    wake_req = level_asserted(s_q.wake_sync[1],
      wake_in_active_high);
    pwr_on = s_q.pwr_sync[1];
    // ****************************************
    // Reference clock request and settling
    // ****************************************
    // Request raised for either radio; the clock is trusted only
    // after the settle counter saturates
    s_d.clk_req = bt_clk_need | wlan_clk_need;
    // Request low: restart the settle count
    if (!s_q.clk_req) begin
      s_d.settle = '0;
      s_d.clk_ok = 1'b0;
    end else if (s_q.settle >= SETTLE_CYC) begin
      // Settled: the clock may now be used
      s_d.clk_ok = 1'b1;
    end else begin
      s_d.settle = s_q.settle + 16'h0001;
    end
    // ****************************************
    // Power state machine
    // ****************************************
    case (s_q.st)
      // Powered off: wait for the synchronised enable,
      // then start initialisation from a clean count
      BHP_OFF: begin
        s_d.cnt = '0;
        if (pwr_on) begin
          s_d.st = BHP_INIT;
        end
      end
      // Initialisation: count out the start-up time,
      // flow control stays not-ready until it ends
      BHP_INIT: begin
        s_d.cnt = s_q.cnt + 16'h0001;
        if (s_q.cnt >= INIT_CYC) begin
          s_d.st = BHP_AWAKE;
        end
      end
      // Awake: leave only when the host releases wake
      // and the internal sleep criteria hold
      BHP_AWAKE: begin
        s_d.cnt = '0;
        if (!wake_req && sleep_criteria_met) begin
          s_d.st = lp_mode_req ? BHP_LOWPWR : BHP_SLEEP;
        end
      end
      // Connection low-power mode on the slow oscillator;
      // wake on the host request or when the interval expires
      BHP_LOWPWR: begin
        s_d.cnt = s_q.cnt + 16'h0001;
        if (wake_req || s_q.cnt >= lp_wake_interval) begin
          s_d.st = BHP_AWAKE;
        end
      end
      // Deep sleep: wake on the host request or when the
      // core itself needs the host's attention
      BHP_SLEEP: begin
        if (wake_req || host_attention_req) begin
          s_d.st = BHP_AWAKE;
        end
      end
      // Unused codes fall back to the safe off state,
      // which then restarts like a cold power-up
      default: begin
        s_d.st = BHP_OFF;
      end
    endcase
    // ****************************************
    // Registered outputs
    // ****************************************
    // Status flags mirror the next state so they change with it
    s_d.awake = st_is_awake(s_d.st);
    s_d.lp_osc = st_is_lowpwr(s_d.st);
    // Host wake follows attention need, polarity selectable
    s_d.host_wake = level_drive(host_attention_req,
      host_wake_active_high);
    // Flow control ready only once initialisation is complete
    s_d.flow_n = !st_is_awake(s_d.st);
    // RF power-downs from registers or packet handler; the packet
    // handler takes over while it marks a packet in flight
    if (st_is_awake(s_d.st)) begin
      if (pkt_rf_active) begin
        s_d.rf_pd = pkt_rf_pd;
      end else begin
        s_d.rf_pd = sw_rf_pd;
      end
    end else begin
      // Nothing runs the radio outside the awake state
      s_d.rf_pd = rf_all_off();
    end
    // Pin drivers enabled only while the core is powered
    s_d.host_wake_oe = pwr_on;
    s_d.clk_req_oe = pwr_on;
    s_d.flow_oe = pwr_on;
    // Shutdown: drop everything, outputs tristated
    if (!pwr_on) begin
      s_d.st = BHP_OFF;
      s_d.cnt = '0;
      s_d.settle = '0;
      s_d.clk_ok = 1'b0;
      s_d.awake = 1'b0;
      s_d.host_wake = 1'b0;
      s_d.clk_req = 1'b0;
      s_d.flow_n = 1'b1;
      s_d.lp_osc = 1'b0;
      s_d.rf_pd = rf_all_off();
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // Asynchronous reset to the power-off values
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      // Safe levels: drivers off, not ready, radio powered down
      s_q <= '{st: BHP_OFF, flow_n: `BHP_FLOW_RST,
               rf_pd: `BHP_RF_OFF,
               default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every output is a field of the state register
  // Host wake pin and its driver enable
  assign host_wake_out = s_q.host_wake;
  assign host_wake_oe = s_q.host_wake_oe;
  // Reference clock request pin and its driver enable
  assign ref_clock_request = s_q.clk_req;
  assign ref_clock_request_oe = s_q.clk_req_oe;
  // Flow control pin, low means ready, and its driver enable
  assign uart_flow_ready_n = s_q.flow_n;
  assign uart_flow_ready_oe = s_q.flow_oe;
  // Internal status
  assign ref_clock_ok = s_q.clk_ok;
  assign core_awake = s_q.awake;
  assign low_power_osc_sel = s_q.lp_osc;
  // Power-down controls for TX, RX, PLL and PA
  assign rf_power_down = s_q.rf_pd;
endmodule

// >>> src/bhp_params.svh
`ifndef BHP_PARAMS_SVH
`define BHP_PARAMS_SVH
// ****************************************
// Timing constants
// ****************************************
`define BHP_CLK_PERIOD_NS 10
`define BHP_SETTLE_NS 5000
`define BHP_SETTLE_CYC ((`BHP_SETTLE_NS + `BHP_CLK_PERIOD_NS - 1) / `BHP_CLK_PERIOD_NS)
`define BHP_INIT_NS 1000
`define BHP_INIT_CYC ((`BHP_INIT_NS + `BHP_CLK_PERIOD_NS - 1) / `BHP_CLK_PERIOD_NS)
`define BHP_LP_WAKE_DEF 16'h0100
`define BHP_CNT_W 16
// ****************************************
// Reset values
// ****************************************
`define BHP_RF_OFF 4'hF
`define BHP_FLOW_RST 1'b1
`endif

// >>> src/bhp_pkg.sv
package bhp_pkg;
  typedef enum logic [2:0] {
    BHP_OFF, BHP_INIT, BHP_AWAKE, BHP_LOWPWR, BHP_SLEEP
  } bhp_state_e;
  typedef struct packed {
    logic tx;
    logic rx;
    logic pll;
    logic pa;
  } bhp_rf_s;
  typedef struct packed {
    logic [1:0] wake_sync;
    logic [1:0] pwr_sync;
    bhp_state_e st;
    logic [15:0] cnt;
    logic [15:0] settle;
    logic clk_ok;
    logic host_wake;
    logic host_wake_oe;
    logic clk_req;
    logic clk_req_oe;
    logic flow_n;
    logic flow_oe;
    logic awake;
    logic lp_osc;
    bhp_rf_s rf_pd;
  } bhp_state_s;
endpackage

// >>> dv/bhp_host_model.sv
`timescale 1ns/10ps
// Host: wake before enable, stays up on host wake
module bhp_host_model (
  input wire logic sys_clk, pwr_req, wake_req, pol, host_wake_out,
  output logic device_wake_in = 1'b0, core_power_enable = 1'b0,
  output logic host_awake = 1'b0
);
  // Pins change just after the rising edge
  always @(posedge sys_clk) begin
    device_wake_in <= wake_req ~^ pol;
    core_power_enable <= pwr_req &
      (core_power_enable | device_wake_in == pol);
    host_awake <= host_wake_out == pol;
  end
endmodule

// >>> dv/bhp_monitor.sv
`timescale 1ns/10ps
// Port checks of the power handshake
module bhp_monitor (
  input wire logic sys_clk, rst, core_power_enable, host_attention_req,
  input wire logic host_wake_active_high, bt_clk_need, wlan_clk_need,
  input wire logic host_wake_out, host_wake_oe, ref_clock_request,
  input wire logic uart_flow_ready_n, uart_flow_ready_oe, ref_clock_ok,
  input wire logic core_awake, input wire bhp_pkg::bhp_rf_s rf_power_down
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Enable low past the sync chain; awake over two cycles
  sequence s_off; !core_power_enable [*5]; endsequence
  sequence s_up; core_awake ##1 core_awake; endsequence
  property p_fl; core_awake |-> !uart_flow_ready_n; endproperty
  a_fl: assert property (p_fl) else $error("flow");
  property p_rq; s_up |-> ref_clock_request ==
    $past(bt_clk_need || wlan_clk_need); endproperty
  a_rq: assert property (p_rq) else $error("clk req");
  property p_hw; s_up |-> host_wake_out ==
    ($past(host_attention_req) ~^ host_wake_active_high); endproperty
  a_hw: assert property (p_hw) else $error("host wake");
  property p_rf; !core_awake |-> rf_power_down == 4'hF; endproperty
  a_rf: assert property (p_rf) else $error("rf");
  property p_sd; s_off |-> !host_wake_oe && !uart_flow_ready_oe; endproperty
  a_sd: assert property (p_sd) else $error("oe");
  property p_rs; s_off |-> !core_awake; endproperty
  a_rs: assert property (p_rs) else $error("reset");
  // Settle count of four: ok stays low four cycles past the rise
  property p_ok; $rose(ref_clock_request) |=> !ref_clock_ok [*4]; endproperty
  a_ok: assert property (p_ok) else $error("settle");
  property p_dn; $fell(ref_clock_request) |-> ##2 !ref_clock_ok; endproperty
  a_dn: assert property (p_dn) else $error("clk ok");
endmodule
bind bhp_power_handshake bhp_monitor mon (.*);

// >>> dv/bhp_power_handshake_test.sv
`timescale 1ns/10ps
// Bench: host model, design and one task per scenario
module bhp_power_handshake_test;
  import bhp_pkg::*;
  logic sys_clk = 0, rst = 1, pwr_req = 0, wake_req = 0, pol = 1;
  logic sleep_criteria_met = 0, host_attention_req = 0, lp_mode_req = 0;
  logic bt_clk_need = 0, wlan_clk_need = 0, pkt_rf_active = 0;
  logic [15:0] lp_wake_interval = 16'h0008;
  bhp_rf_s sw_rf_pd = 4'h5, pkt_rf_pd = 4'hA, rf_power_down;
  logic core_power_enable, device_wake_in, host_wake_out, host_wake_oe;
  logic ref_clock_request, ref_clock_request_oe, uart_flow_ready_n;
  logic uart_flow_ready_oe, ref_clock_ok, core_awake, low_power_osc_sel;
  logic host_awake;
  wire wake_in_active_high = pol, host_wake_active_high = pol;
  int n_fail = 0, checked = 0, cyc = 0;
  bhp_power_handshake #(.SETTLE_CYC(16'h0004), .INIT_CYC(16'h0004))
    DUT (.*);
  bhp_host_model host (.*);
  // Clock and run limit
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (++cyc == 3000) begin
    n_fail++;
    results;
  end
  task results;
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [4:0] a, input logic [4:0] e);
    checked++;
    if (a !== e) begin
      n_fail++;
      $display("MISMATCH %0t %h %h", $time, a, e);
    end
  endtask
  task nc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task wa(input logic v);
    for (int i = 0; i < 40 && core_awake !== v; i++) @(negedge sys_clk);
  endtask
  // Shutdown, then cold power-up with polarity p
  task t_up(input logic p);
    pwr_req = 0;
    nc(8);
    chk({host_wake_oe, ref_clock_request_oe, uart_flow_ready_oe,
      core_awake}, 5'h0);
    pol = p;
    wake_req = 1;
    pwr_req = 1;
    wa(1);
    chk({core_awake, uart_flow_ready_n, host_wake_out},
      {2'b10, ~p});
    chk({host_wake_oe, ref_clock_request_oe,
      uart_flow_ready_oe}, 5'h7);
    host_attention_req = 1;
    nc(2);
    chk({host_wake_out, host_awake}, {p, 1'b1});
    host_attention_req = 0;
  endtask
  // Each source raises the request; ok follows after settling
  task t_ck;
    for (int k = 0; k < 2; k++) begin
      {bt_clk_need, wlan_clk_need} = k ? 2'b01 : 2'b10;
      nc(1);
      chk({ref_clock_request, ref_clock_ok}, 5'h2);
      nc(8);
      chk(ref_clock_ok, 5'h1);
      {bt_clk_need, wlan_clk_need} = 2'b00;
      nc(4);
    end
  endtask
  // Register and packet sources of the RF power-downs
  task t_rf;
    pkt_rf_active = 0;
    nc(2);
    chk(rf_power_down, 5'h5);
    pkt_rf_active = 1;
    nc(2);
    chk(rf_power_down, 5'hA);
  endtask
  // Sleep gated by wake and criteria, then timed wake
  task t_sl;
    lp_mode_req = 0;
    wake_req = 0;
    nc(8);
    chk(core_awake, 5'h1);
    sleep_criteria_met = 1;
    wa(0);
    chk({core_awake, rf_power_down}, 5'h0F);
    wake_req = 1;
    wa(1);
    chk(core_awake, 5'h1);
    lp_mode_req = 1;
    wake_req = 0;
    wa(0);
    chk({core_awake, low_power_osc_sel}, 5'h1);
    sleep_criteria_met = 0;
    wa(1);
    chk(core_awake, 5'h1);
  endtask
  // Main sequence
  initial begin
    nc(8);
    rst = 0;
    t_up(1);
    t_ck;
    t_rf;
    t_sl;
    t_up(0);
    t_sl;
    results;
  end
endmodule
